// File: dev_cache_mem.sv
// Purpose: per-domain cache of the last fetched table byte
// Assumes: one write and one read port on the same clock
// Notes: read data is registered, one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module dev_cache_mem (
	// clock
	input wire logic clk,
	// write port
	input wire logic we,
	input wire dev_pkg::dom_t waddr,
	input wire dev_pkg::cache_line_s wdata,
	// read port
	input wire dev_pkg::dom_t raddr,
	output dev_pkg::cache_line_s rdata
);
	dev_pkg::cache_line_s mem [dev_pkg::DOMAINS];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // dev_cache_mem
`default_nettype wire

// File: dev_pkg.sv
// Purpose: constants and carrier types for the dma exclusion vector checker
// Assumes: 32-bit configuration words, 40-bit physical addresses
// Notes: cfg and dma request formats are packed here so the checker and the bench share them
// Functional notes
// [RL1] every table bit governs exactly one 4KB page of physical space
// [RL2] lowest page is bit 0 of byte at base, then upward in bit, byte order
// [RL3] a set page bit refuses the dma access and answers with master abort
// [RL4] the page check covers dma to system memory and to memory-mapped io
// [RL5] several domains, each with its own table, chosen by request source
// [RL6] fetched table bytes are cached per domain to save memory reads
// [RL7] select function field picks one of eight indirect regs, index picks instance
// [RL8] software writes select first, then reads or writes the data port
// [RL9] header reads fixed id, zero next pointer and zero block type, all read-only
// [RL10] header shows irq reporting absent (bit 21) and machine check present (bit 20)
// [RL11] software writes only 00h..07h into function field bits 15:8
// [RL12] index stays below domain count, or map total for the map register
// [RL13] without virtualization support header, select, port and indirect regs are reserved
// [RL14] table base is low register bits 31:12 joined with high register bits
// [RL15] size field 6:2 covers 4GB times 2^size with 128KB times 2^size table
// [RL16] protect bit 1 clear allows out-of-range dma, set blocks it
// [RL17] enable bit 0 set uses the table, clear allows every access of the domain
// [RL18] one low base register per domain, selected by index, reset to zero
// [RL19] software keeps tables wholly in non-cacheable or write-through system memory
// [RL20] high base register holds base bits 39:32 in its low byte
// [RL21] a source matching no map entry is checked against domain zero
// [RL22] domain count reads as constant 08h, fixing base register instances
// [RL23] byte is base plus page/8, tested bit is page mod 8
// [RL24] address out of range when its page passes the table's bit count
package dev_pkg;
	// ----------------------------------------
	// register offsets and header
	// ----------------------------------------
	localparam logic [7:0] OFS_HEADER = 8'hf0;
	localparam logic [7:0] OFS_SELECT = 8'hf4;
	localparam logic [7:0] OFS_DATA = 8'hf8;
	localparam logic [7:0] CAP_IDENTIFIER = 8'h0f;
	localparam logic [7:0] NEXT_CAP_POINTER = 8'h00;
	localparam logic [2:0] CAP_BLOCK_TYPE = 3'h0;
	localparam logic IRQ_REPORT_CAPABLE = 1'b0;
	localparam logic MACHINE_CHECK_REPORT_CAPABLE = 1'b1;
	localparam logic [31:0] HEADER_VALUE = {10'h000, IRQ_REPORT_CAPABLE,
		MACHINE_CHECK_REPORT_CAPABLE, 1'b0, CAP_BLOCK_TYPE, NEXT_CAP_POINTER, CAP_IDENTIFIER};
	localparam logic [15:0] SELECT_MASK = 16'hffff;
	// ----------------------------------------
	// indirect registers
	// ----------------------------------------
	localparam logic [7:0] FN_BASE_LOW = 8'h00;
	localparam logic [7:0] FN_BASE_HIGH = 8'h01;
	localparam logic [7:0] FN_MAP = 8'h02;
	localparam logic [7:0] FN_CAPS = 8'h03;
	localparam int DOMAINS = 8;
	localparam int UNIT_MAPS = 4;
	localparam int REQ_MAPS = 8;
	localparam int MAPS = UNIT_MAPS + REQ_MAPS;
	localparam logic [7:0] DOMAIN_COUNT = 8'h08;
	localparam logic [7:0] UNIT_MAP_COUNT = 8'h04;
	localparam logic [7:0] REQUESTER_MAP_COUNT = 8'h08;
	localparam logic [7:0] CAP_REVISION = 8'h01;
	localparam logic [31:0] CAPS_VALUE = {REQUESTER_MAP_COUNT, UNIT_MAP_COUNT,
		DOMAIN_COUNT, CAP_REVISION};
	localparam logic [31:0] BASE_LOW_MASK = 32'hffff_f07f;
	localparam logic [31:0] BASE_HIGH_MASK = 32'h0000_00ff;
	localparam logic [31:0] UNIT_MAP_MASK = 32'h1c7f_ffff;
	localparam logic [31:0] REQ_MAP_MASK = 32'hffff_1c01;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BASE_LSB = 12;
	localparam int SIZE_MSB = 6;
	localparam int SIZE_LSB = 2;
	localparam int PROTECT_BIT = 1;
	localparam int ENABLE_BIT = 0;
	localparam int PAGE_SHIFT = 12;
	localparam int BYTE_BITS = 3;
	localparam logic [5:0] REGION_PAGE_BITS = 6'h14;
	localparam int U_DOM1_LSB = 26;
	localparam int U_DOM0_LSB = 20;
	localparam int U_BUS_LSB = 12;
	localparam int U_VALID1 = 11;
	localparam int U_UNIT1_LSB = 6;
	localparam int U_VALID0 = 5;
	localparam int U_UNIT0_LSB = 0;
	localparam int R_RID_LSB = 16;
	localparam int R_DOM_LSB = 10;
	localparam int R_VALID = 0;
	localparam int ADDR_W = 40;
	localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef logic [2:0] dom_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOOK,
		ST_FETCH
	} fsm_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} cfg_req_s;
	typedef struct packed {
		logic valid;
		logic [7:0] bus;
		logic [4:0] unit;
		logic [15:0] rid;
		logic [ADDR_W-1:0] addr;
	} dma_req_s;
	typedef struct packed {
		logic [ADDR_W-1:0] tag;
		logic [7:0] data;
	} cache_line_s;
endpackage

// File: dev_table_mem.sv
// Purpose: behavioural system memory holding the exclusion tables read by the checker
// Assumes: one outstanding byte read at a time, answer delay set by the bench
// Notes: read data toggles while idle so a stale byte is never mistaken for an answer
`timescale 1ns/100ps
`default_nettype none
module dev_table_mem (
	// clock
	input wire logic clk,
	// byte read request
	input wire logic rd_req,
	input wire logic [dev_pkg::ADDR_W-1:0] rd_addr,
	// answer delay in cycles, at least one
	input wire logic [3:0] lat,
	// answer
	output logic rd_valid,
	output logic [7:0] rd_data
);
	// tables live wholly in plain system memory; unwritten bytes read as zero
	logic [7:0] bytes [logic [dev_pkg::ADDR_W-1:0]];
	logic [dev_pkg::ADDR_W-1:0] addr_hold;
	logic [3:0] wait_cnt;
	logic busy;

	task automatic poke(input logic [dev_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		bytes[a] = d;
	endtask

	initial begin
		rd_valid = 1'b0;
		rd_data = 8'h5a;
		busy = 1'b0;
		wait_cnt = 4'h0;
		addr_hold = '0;
	end

	always @(posedge clk) begin
		rd_valid <= 1'b0;
		rd_data <= ~rd_data;
		if (rd_req) begin
			busy <= 1'b1;
			addr_hold <= rd_addr;
			wait_cnt <= lat;
		end else if (busy) begin
			if (wait_cnt <= 4'h1) begin
				busy <= 1'b0;
				rd_valid <= 1'b1;
				rd_data <= bytes.exists(addr_hold) ? bytes[addr_hold] : 8'h00;
			end else begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule // dev_table_mem
`default_nettype wire

// File: dma_exclusion_vector_check.sv
// Purpose: checks external dma requests against per-domain page tables
// Assumes: register port and memory read port are synchronous to clk
// Notes: violations raise a machine-check pulse; there is no interrupt
`timescale 1ns/100ps
`default_nettype none
module dma_exclusion_vector_check (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// strap
	input wire logic virtualization_supported,
	// configuration port
	input wire dev_pkg::cfg_req_s cfg,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// dma request and answer
	input wire dev_pkg::dma_req_s dma,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_abort,
	output logic machine_check_event,
	// table memory reads
	output logic mem_rd_req,
	output logic [dev_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_rd_valid,
	input wire logic [7:0] mem_rd_data
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dev_pkg::fsm_e fsm;
		logic [15:0] sel;
		logic [dev_pkg::DOMAINS-1:0][31:0] base_lo;
		logic [dev_pkg::DOMAINS-1:0][7:0] base_hi;
		logic [dev_pkg::MAPS-1:0][31:0] maps;
		logic [dev_pkg::DOMAINS-1:0] cache_ok;
		dev_pkg::dom_t dom;
		logic [dev_pkg::PAGE_W-1:0] page;
		logic [dev_pkg::ADDR_W-1:0] byte_addr;
		logic [31:0] rdata;
		logic rvalid;
		logic ready;
		logic resp_valid;
		logic resp_abort;
		logic mce;
		logic mem_req;
	} state_s;

	state_s st_reg;
	state_s st_next;
	dev_pkg::cache_line_s cache_rd;
	dev_pkg::cache_line_s cache_wr;
	logic cache_we;
	dev_pkg::dom_t cache_raddr;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// true when the selected index names an existing instance
	function automatic logic inst_ok(input logic [7:0] fn, input logic [7:0] idx);
		logic ok;
		ok = 1'b1;
		case (fn)
			dev_pkg::FN_BASE_LOW, dev_pkg::FN_BASE_HIGH: ok = idx < dev_pkg::DOMAIN_COUNT;
			dev_pkg::FN_MAP: ok = idx < (dev_pkg::UNIT_MAP_COUNT + dev_pkg::REQUESTER_MAP_COUNT);
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction

	// domain of a request; requester-id entries override unit-id entries
	function automatic dev_pkg::dom_t resolve_dom(input state_s s, input dev_pkg::dma_req_s r);
		dev_pkg::dom_t d;
		logic [31:0] m;
		d = '0; // RL21
		for (int i = 0; i < dev_pkg::UNIT_MAPS; i++) begin
			m = s.maps[i];
			if (m[dev_pkg::U_BUS_LSB +: 8] == r.bus) begin
				if (m[dev_pkg::U_VALID0] && m[dev_pkg::U_UNIT0_LSB +: 5] == r.unit) begin
					d = m[dev_pkg::U_DOM0_LSB +: 3]; // RL5
				end
				if (m[dev_pkg::U_VALID1] && m[dev_pkg::U_UNIT1_LSB +: 5] == r.unit) begin
					d = m[dev_pkg::U_DOM1_LSB +: 3]; // RL5
				end
			end
		end
		for (int i = dev_pkg::UNIT_MAPS; i < dev_pkg::MAPS; i++) begin
			m = s.maps[i];
			if (m[dev_pkg::R_VALID] && m[dev_pkg::R_RID_LSB +: 16] == r.rid) begin
				d = m[dev_pkg::R_DOM_LSB +: 3]; // RL5
			end
		end
		return d;
	endfunction

	// byte address holding the bit of a page in a domain's table
	function automatic logic [dev_pkg::ADDR_W-1:0] table_byte(input state_s s,
		input dev_pkg::dom_t d, input logic [dev_pkg::PAGE_W-1:0] p);
		logic [dev_pkg::ADDR_W-1:0] base;
		base = {s.base_hi[d], s.base_lo[d][31:dev_pkg::BASE_LSB],
			{dev_pkg::BASE_LSB{1'b0}}}; // RL14 RL20
		return base + {{(dev_pkg::ADDR_W - dev_pkg::PAGE_W + dev_pkg::BYTE_BITS){1'b0}},
			p[dev_pkg::PAGE_W-1:dev_pkg::BYTE_BITS]}; // RL23
	endfunction

	// ----------------------------------------
	// decoded fields of the current domain
	// ----------------------------------------
	logic [31:0] cur_lo;
	logic cur_enable;
	logic cur_protect;
	logic [5:0] cur_shift;
	logic cur_out;
	logic [dev_pkg::ADDR_W-1:0] cur_byte;
	logic cache_hit;
	logic [7:0] fn;
	logic [7:0] idx;
	logic sel_ok;

	always_comb begin
		cur_lo = st_reg.base_lo[st_reg.dom];
		cur_enable = cur_lo[dev_pkg::ENABLE_BIT];
		cur_protect = cur_lo[dev_pkg::PROTECT_BIT];
		// table of 2^(20+size) bits covers 4GB * 2^size
		cur_shift = dev_pkg::REGION_PAGE_BITS
			+ {1'b0, cur_lo[dev_pkg::SIZE_MSB:dev_pkg::SIZE_LSB]}; // RL15
		cur_out = (st_reg.page >> cur_shift) != '0; // RL24
		cur_byte = table_byte(st_reg, st_reg.dom, st_reg.page);
		cache_hit = st_reg.cache_ok[st_reg.dom] && cache_rd.tag == cur_byte; // RL6
		fn = st_reg.sel[15:8];
		idx = st_reg.sel[7:0];
		sel_ok = inst_ok(fn, idx);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.resp_valid = 1'b0;
		st_next.resp_abort = 1'b0;
		st_next.mce = 1'b0;
		st_next.mem_req = 1'b0;
		cache_we = 1'b0;
		cache_wr = '{tag: st_reg.byte_addr, data: mem_rd_data};
		cache_raddr = st_reg.dom;

		// register reads; everything is reserved without virtualization
		if (cfg.rd) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = dev_pkg::WORD_RESET;
			if (virtualization_supported) begin // RL13
				case (cfg.addr)
					dev_pkg::OFS_HEADER: st_next.rdata = dev_pkg::HEADER_VALUE; // RL9 RL10
					dev_pkg::OFS_SELECT: st_next.rdata = {16'h0000, st_reg.sel};
					dev_pkg::OFS_DATA: begin
						if (sel_ok) begin
							case (fn) // RL7
								dev_pkg::FN_BASE_LOW: st_next.rdata = st_reg.base_lo[idx[2:0]];
								dev_pkg::FN_BASE_HIGH: st_next.rdata = {24'h00_0000,
									st_reg.base_hi[idx[2:0]]};
								dev_pkg::FN_MAP: st_next.rdata = st_reg.maps[idx[3:0]];
								dev_pkg::FN_CAPS: st_next.rdata = dev_pkg::CAPS_VALUE; // RL22
								default: st_next.rdata = dev_pkg::WORD_RESET;
							endcase
						end
					end
					default: st_next.rdata = dev_pkg::WORD_RESET;
				endcase
			end
		end

		// register writes
		if (cfg.wr && virtualization_supported) begin // RL13
			if (cfg.addr == dev_pkg::OFS_SELECT) begin
				st_next.sel = cfg.wdata[15:0] & dev_pkg::SELECT_MASK; // RL7
			end else if (cfg.addr == dev_pkg::OFS_DATA && sel_ok) begin
				case (fn)
					dev_pkg::FN_BASE_LOW: begin
						st_next.base_lo[idx[2:0]] = cfg.wdata & dev_pkg::BASE_LOW_MASK; // RL18
						st_next.cache_ok = '0;
					end
					dev_pkg::FN_BASE_HIGH: begin
						st_next.base_hi[idx[2:0]] = cfg.wdata[7:0]; // RL20
						st_next.cache_ok = '0;
					end
					dev_pkg::FN_MAP: begin
						st_next.maps[idx[3:0]] = cfg.wdata & ((idx < dev_pkg::UNIT_MAP_COUNT)
							? dev_pkg::UNIT_MAP_MASK : dev_pkg::REQ_MAP_MASK);
					end
					default: st_next.sel = st_reg.sel;
				endcase
			end
		end

		// dma checking; memory and mmio targets are treated alike
		case (st_reg.fsm)
			dev_pkg::ST_IDLE: begin
				if (dma.valid && st_reg.ready) begin
					st_next.dom = resolve_dom(st_reg, dma);
					st_next.page = dma.addr[dev_pkg::ADDR_W-1:dev_pkg::PAGE_SHIFT]; // RL1 RL4
					cache_raddr = st_next.dom;
					st_next.fsm = dev_pkg::ST_LOOK;
				end
			end
			dev_pkg::ST_LOOK: begin
				st_next.byte_addr = cur_byte;
				if (!cur_enable) begin
					st_next.resp_valid = 1'b1; // RL17
					st_next.fsm = dev_pkg::ST_IDLE;
				end else if (cur_out) begin
					st_next.resp_valid = 1'b1;
					st_next.resp_abort = cur_protect; // RL16
					st_next.mce = cur_protect;
					st_next.fsm = dev_pkg::ST_IDLE;
				end else if (cache_hit) begin
					st_next.resp_valid = 1'b1;
					st_next.resp_abort = cache_rd.data[st_reg.page[2:0]]; // RL2 RL3
					st_next.mce = cache_rd.data[st_reg.page[2:0]];
					st_next.fsm = dev_pkg::ST_IDLE;
				end else begin
					st_next.mem_req = 1'b1;
					st_next.fsm = dev_pkg::ST_FETCH;
				end
			end
			dev_pkg::ST_FETCH: begin
				if (mem_rd_valid) begin
					cache_we = 1'b1; // RL6
					// a base rewrite in the same cycle leaves the line invalid
					if (!(cfg.wr && virtualization_supported && cfg.addr == dev_pkg::OFS_DATA
						&& (fn == dev_pkg::FN_BASE_LOW || fn == dev_pkg::FN_BASE_HIGH))) begin
						st_next.cache_ok[st_reg.dom] = 1'b1;
					end
					st_next.resp_valid = 1'b1;
					st_next.resp_abort = mem_rd_data[st_reg.page[2:0]]; // RL2 RL3
					st_next.mce = mem_rd_data[st_reg.page[2:0]];
					st_next.fsm = dev_pkg::ST_IDLE;
				end
			end
			default: st_next.fsm = dev_pkg::ST_IDLE;
		endcase
		st_next.ready = st_next.fsm == dev_pkg::ST_IDLE;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_reg <= '0; // RL18
			st_reg.fsm <= dev_pkg::ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	dev_cache_mem u_cache (
		.clk(clk),
		.we(cache_we),
		.waddr(st_reg.dom),
		.wdata(cache_wr),
		.raddr(cache_raddr),
		.rdata(cache_rd)
	);

	assign cfg_rdata = st_reg.rdata;
	assign cfg_rvalid = st_reg.rvalid;
	assign req_ready = st_reg.ready;
	assign resp_valid = st_reg.resp_valid;
	assign resp_abort = st_reg.resp_abort;
	assign machine_check_event = st_reg.mce;
	assign mem_rd_req = st_reg.mem_req;
	assign mem_rd_addr = st_reg.byte_addr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	base_reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // RL18
		!resetn |=> st_reg.base_lo == '0)
		else $error("base registers not zero after reset");

	header_value_a: assert property ( // RL9 RL10
		cfg.rd && virtualization_supported && cfg.addr == dev_pkg::OFS_HEADER
		|=> cfg_rvalid && cfg_rdata[21] == 1'b0 && cfg_rdata[20] == 1'b1
			&& cfg_rdata[7:0] == dev_pkg::CAP_IDENTIFIER && cfg_rdata[18:8] == '0)
		else $error("capability header reads wrong");

	reserved_read_a: assert property ( // RL13
		cfg.rd && !virtualization_supported |=> cfg_rvalid && cfg_rdata == '0)
		else $error("register visible without virtualization");

	select_store_a: assert property ( // RL7
		cfg.wr && virtualization_supported && cfg.addr == dev_pkg::OFS_SELECT
		|=> st_reg.sel == $past(cfg.wdata[15:0]))
		else $error("select register not updated");

	disabled_allow_a: assert property ( // RL17
		st_reg.fsm == dev_pkg::ST_LOOK && !cur_enable |=> resp_valid && !resp_abort)
		else $error("disabled domain did not allow access");

	out_range_a: assert property ( // RL16
		st_reg.fsm == dev_pkg::ST_LOOK && cur_enable && cur_out
		|=> resp_valid && resp_abort == $past(cur_protect))
		else $error("out-of-range answer wrong");

	fetch_address_a: assert property ( // RL23 RL14
		mem_rd_req |-> mem_rd_addr == table_byte(st_reg, st_reg.dom, st_reg.page)
			&& st_reg.fsm == dev_pkg::ST_FETCH)
		else $error("table fetch address wrong");

	abort_reports_a: assert property ( // RL3
		resp_valid |-> machine_check_event == resp_abort)
		else $error("abort not reported to machine check");

	unmatched_domain_a: assert property ( // RL21
		dma.valid && req_ready && st_reg.maps == '0 |=> st_reg.dom == '0)
		else $error("unmapped source not sent to domain zero");

	select_reserved_a: assert property ( // RL13
		cfg.wr && !virtualization_supported |=> $stable(st_reg.sel) && $stable(st_reg.base_lo))
		else $error("register written without virtualization");

	cache_hit_a: assert property ( // RL6
		st_reg.fsm == dev_pkg::ST_LOOK && cur_enable && !cur_out && cache_hit
		|=> resp_valid && !mem_rd_req)
		else $error("cache hit still read memory");

	cache_miss_a: assert property ( // RL6
		st_reg.fsm == dev_pkg::ST_LOOK && cur_enable && !cur_out && !cache_hit
		|=> mem_rd_req && !resp_valid)
		else $error("cache miss did not fetch");

	fill_abort_a: assert property ( // RL3
		st_reg.fsm == dev_pkg::ST_FETCH && mem_rd_valid && mem_rd_data[st_reg.page[2:0]]
		|=> resp_valid && resp_abort && machine_check_event)
		else $error("protected page not aborted");

	fill_allow_a: assert property ( // RL2
		st_reg.fsm == dev_pkg::ST_FETCH && mem_rd_valid && !mem_rd_data[st_reg.page[2:0]]
		|=> resp_valid && !resp_abort)
		else $error("open page aborted");
endmodule // dma_exclusion_vector_check
`default_nettype wire

// File: dma_exclusion_vector_check_bench.sv
// Purpose: self-checking bench for the dma exclusion vector checker
// Assumes: table memory modelled by dev_table_mem with a settable delay
// Notes: every scenario is a task; outputs are sampled at the rising edge
`timescale 1ns/100ps
`default_nettype none
module dma_exclusion_vector_check_bench;
	logic clk;
	logic resetn;
	logic virtualization_supported;
	dev_pkg::cfg_req_s cfg;
	dev_pkg::dma_req_s dma;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid, req_ready, resp_valid, resp_abort, machine_check_event;
	logic mem_rd_req, mem_rd_valid;
	logic [dev_pkg::ADDR_W-1:0] mem_rd_addr;
	logic [7:0] mem_rd_data;
	logic [3:0] mem_lat;
	int errors;
	int num_checks;

	dma_exclusion_vector_check DUT (.clk(clk), .resetn(resetn),
		.virtualization_supported(virtualization_supported), .cfg(cfg),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .dma(dma), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_abort(resp_abort),
		.machine_check_event(machine_check_event), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

	dev_table_mem mem (.clk(clk), .rd_req(mem_rd_req), .rd_addr(mem_rd_addr), .lat(mem_lat),
		.rd_valid(mem_rd_valid), .rd_data(mem_rd_data));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// reporting and bus tasks
	// ----------------------------------------
	task automatic conclude();
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic fail_wait(input string what);
		errors++;
		$display("MISMATCH %s expected high seen low", what);
		conclude();
	endtask

	task automatic check_word(input string what, input logic [39:0] exp, input logic [39:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cfg <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		cfg <= '0;
	endtask

	task automatic cfg_expect(input logic [7:0] a, input logic [31:0] exp, input string what);
		int n;
		@(posedge clk);
		cfg <= {1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk);
		cfg <= '0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cfg_rvalid !== 1'b1 && n < 8);
		if (n >= 8) fail_wait("cfg_rvalid");
		check_word(what, {8'h00, exp}, {8'h00, cfg_rdata});
	endtask

	// select is always written before the data port, with legal function and index
	task automatic ind_wr(input logic [7:0] fn, input logic [7:0] idx, input logic [31:0] d);
		cfg_wr(dev_pkg::OFS_SELECT, {16'h0000, fn, idx});
		cfg_wr(dev_pkg::OFS_DATA, d);
	endtask

	task automatic ind_expect(input logic [7:0] fn, input logic [7:0] idx,
		input logic [31:0] exp, input string what);
		cfg_wr(dev_pkg::OFS_SELECT, {16'h0000, fn, idx});
		cfg_expect(dev_pkg::OFS_DATA, exp, what);
	endtask

	// request held until taken; a fetch seen on the way is recorded with its address
	task automatic dma_op(input logic [7:0] b, input logic [4:0] u, input logic [15:0] r,
		input logic [39:0] a, input logic exp_abort, input logic exp_fetch,
		input logic [39:0] exp_ma);
		logic fetched;
		logic [39:0] ma;
		int n;
		fetched = 1'b0;
		ma = '0;
		@(posedge clk);
		dma <= {1'b1, b, u, r, a};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		dma.valid <= 1'b0;
		if (n >= 50) fail_wait("req_ready");
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (mem_rd_req === 1'b1) begin
				fetched = 1'b1;
				ma = mem_rd_addr;
			end
		end while (resp_valid !== 1'b1 && n < 50);
		if (n >= 50) fail_wait("resp_valid");
		check_bit("resp_abort", exp_abort, resp_abort);
		check_bit("machine_check_event", exp_abort, machine_check_event);
		check_bit("table_fetch", exp_fetch, fetched);
		if (exp_fetch) check_word("mem_rd_addr", exp_ma, ma);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic regs_reset();
		cfg_expect(dev_pkg::OFS_HEADER, dev_pkg::HEADER_VALUE, "header");
		cfg_expect(dev_pkg::OFS_SELECT, 32'h0000_0000, "select");
		for (int i = 0; i < 8; i++) ind_expect(dev_pkg::FN_BASE_LOW, 8'(i), 0, "base_low");
		ind_expect(dev_pkg::FN_CAPS, 8'h00, dev_pkg::CAPS_VALUE, "caps");
	endtask

	task automatic regs_access();
		cfg_wr(dev_pkg::OFS_HEADER, 32'hffff_ffff);
		cfg_expect(dev_pkg::OFS_HEADER, dev_pkg::HEADER_VALUE, "header_ro");
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h07, 32'hffff_ffff);
		ind_expect(dev_pkg::FN_BASE_LOW, 8'h07, dev_pkg::BASE_LOW_MASK, "base_low7");
		ind_wr(dev_pkg::FN_BASE_HIGH, 8'h07, 32'hffff_ffff);
		ind_expect(dev_pkg::FN_BASE_HIGH, 8'h07, 32'h0000_00ff, "base_high7");
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h07, 32'h0000_0000);
		ind_wr(dev_pkg::FN_BASE_HIGH, 8'h07, 32'h0000_0000);
		for (int f = 4; f < 8; f++) ind_expect(8'(f), 8'h00, 0, "spare_fn");
		cfg_expect(dev_pkg::OFS_SELECT, 32'h0000_0700, "select_rb");
		cfg_expect(8'hfc, 32'h0000_0000, "unmapped");
	endtask

	task automatic dma_pages();
		dma_op(0, 0, 0, 40'h00_0001_3000, 0, 0, 0);
		mem.poke(40'h00_0010_0000, 8'h01);
		mem.poke(40'h00_0010_0002, 8'h08);
		mem.poke(40'h00_0011_fd80, 8'h01);
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h00, 32'h0010_0001);
		dma_op(0, 0, 0, 40'h00_0001_3000, 1, 1, 40'h00_0010_0002);
		dma_op(0, 0, 0, 40'h00_0001_2fff, 0, 0, 0);
		mem_lat <= 4'h6;
		dma_op(0, 0, 0, 40'h00_0000_0000, 1, 1, 40'h00_0010_0000);
		mem_lat <= 4'h1;
		dma_op(0, 0, 0, 40'h00_0000_1000, 0, 0, 0);
		dma_op(0, 0, 0, 40'h00_fec0_0000, 1, 1, 40'h00_0011_fd80);
	endtask

	task automatic dma_ranges();
		dma_op(0, 0, 0, 40'h01_0000_0000, 0, 0, 0);
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h00, 32'h0010_0003);
		dma_op(0, 0, 0, 40'h01_0000_0000, 1, 0, 0);
		mem.poke(40'h00_0012_0000, 8'h01);
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h00, 32'h0010_0005);
		dma_op(0, 0, 0, 40'h01_0000_0000, 1, 1, 40'h00_0012_0000);
		dma_op(0, 0, 0, 40'h02_0000_0000, 0, 0, 0);
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h00, 32'h0010_0007);
		dma_op(0, 0, 0, 40'h02_0000_0000, 1, 0, 0);
	endtask

	task automatic dma_domains();
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h00, 32'h0010_0001);
		ind_wr(dev_pkg::FN_BASE_LOW, 8'h02, 32'h0020_0001);
		ind_wr(dev_pkg::FN_BASE_HIGH, 8'h02, 32'h0000_0001);
		ind_wr(dev_pkg::FN_MAP, 8'h00, 32'h0020_3025);
		mem.poke(40'h01_0020_0000, 8'h20);
		dma_op(3, 5, 0, 40'h00_0000_5000, 1, 1, 40'h01_0020_0000);
		dma_op(3, 6, 0, 40'h00_0000_5000, 0, 1, 40'h00_0010_0000);
		ind_wr(dev_pkg::FN_MAP, 8'h04, 32'h0abc_0401);
		dma_op(3, 5, 16'h0abc, 40'h00_0000_5000, 0, 0, 0);
	endtask

	task automatic virt_off();
		@(posedge clk);
		virtualization_supported <= 1'b0;
		cfg_expect(dev_pkg::OFS_HEADER, 32'h0000_0000, "header_off");
		cfg_wr(dev_pkg::OFS_SELECT, 32'h0000_0300);
		@(posedge clk);
		virtualization_supported <= 1'b1;
		cfg_expect(dev_pkg::OFS_SELECT, 32'h0000_0204, "select_kept");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		virtualization_supported = 1'b1;
		cfg = '0;
		dma = '0;
		mem_lat = 4'h1;
		errors = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		regs_reset();
		regs_access();
		dma_pages();
		dma_ranges();
		dma_domains();
		virt_off();
		conclude();
	end
endmodule // dma_exclusion_vector_check_bench
`default_nettype wire
